// ---- logic/intreg_consts.vh ----
`ifndef INTREG_CONSTS_VH
`define INTREG_CONSTS_VH

// ----------------------------------------------------------------
// Widths and sizes
// ----------------------------------------------------------------
`define WORD_W       64
`define IDX_W        6
`define REG_COUNT    64
`define STORE_SLICES 2
`define ADD_SLICES   8
`define ADD_SLICE_W  8
`define ADD_LATENCY  4
`define BUF_W        68
`define CREDIT_MAX   2'h2

// ----------------------------------------------------------------
// Major opcodes and jump sub-codes
// ----------------------------------------------------------------
`define OP_JUMP      9'h005
`define JUMP_PLAIN   3'h0
`define JUMP_FLUSH   3'h1
`define OP_B_TO_A    9'h014
`define OP_A_TO_B    9'h015
`define OP_ADD_A     9'h018
`define OP_SUB_A     9'h019
`define OP_MEM_TO_B  9'h01c
`define OP_B_TO_MEM  9'h01d
`define OP_MEM_TO_T  9'h01e
`define OP_T_TO_MEM  9'h01f
`define OP_ADD_S     9'h030
`define OP_SUB_S     9'h031
`define OP_T_TO_S    9'h03c
`define OP_S_TO_T    9'h03d

// ----------------------------------------------------------------
// Word constants
// ----------------------------------------------------------------
`define LEGACY_MASK  64'h0000_0000_ffff_ffff
`define FULL_MASK    64'hffff_ffff_ffff_ffff
`define SIGN_BIT     64'h8000_0000_0000_0000
`define ONE_WORD     64'h0000_0000_0000_0001
`define ZERO_WORD    64'h0000_0000_0000_0000
`define IDX_ONE      6'h01

`endif

// ---- logic/result_skid_buffer.v ----
`timescale 1ns/10ps

module result_skid_buffer #(
  parameter WIDTH = 68                   // Entry width
) (
  input  wire             mclk_i,        // Processor clock
  input  wire             reset_i,       // Synchronous reset, high
  input  wire             in_valid_i,    // Producer has a word
  output wire             in_ready_o,    // Room for a word
  input  wire [WIDTH-1:0] in_data_i,     // Producer word
  output wire             out_valid_o,   // Head word valid
  input  wire             out_ready_i,   // Consumer takes head
  output wire [WIDTH-1:0] out_data_o     // Head word
);

  reg             head_valid;            // Entry 0 occupied
  reg             tail_valid;            // Entry 1 occupied
  reg [WIDTH-1:0] head_data;             // Entry 0, drives output
  reg [WIDTH-1:0] tail_data;             // Entry 1, skid slot

  wire pop  = head_valid & out_ready_i;  // Head leaves
  wire push = in_valid_i & ~tail_valid;  // Word arrives

  assign in_ready_o  = ~tail_valid;      // Full only when both held
  assign out_valid_o = head_valid;
  assign out_data_o  = head_data;

  // ----------------------------------------------------------------
  // Two-entry queue; the output side is always a flop so a stalled
  // consumer never sees data change under it
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (reset_i) begin
      head_valid <= 1'b0;
      tail_valid <= 1'b0;
      head_data  <= {WIDTH{1'b0}};
    end else if (pop) begin
      // Tail moves up, or new word lands at head
      if (tail_valid) begin
        head_data  <= tail_data;
        tail_valid <= push;
        if (push)
          tail_data <= in_data_i;
      end else begin
        head_valid <= push;
        if (push)
          head_data <= in_data_i;
      end
    end else if (push) begin
      // No pop: fill the first free slot
      if (!head_valid) begin
        head_valid <= 1'b1;
        head_data  <= in_data_i;
      end else begin
        tail_valid <= 1'b1;
        tail_data  <= in_data_i;
      end
    end
  end

endmodule

// ---- logic/intermediate_regfile_and_adder.v ----
// Functional notes
// - 64 address and 64 scalar side registers
// - Every intermediate register is 64 bits
// - They back primary address and scalar registers
// - Two 32-bit storage slices, interleaved 16-bit halves
// - Writes from primary registers, memory, branch control
// - Jump to address register; flush form maintenance-only
// - Copy address-side register to primary address
// - Copy primary address into address-side register
// - Block read memory into address-side registers
// - Block write address-side registers to memory
// - Block read memory into scalar-side registers
// - Block write scalar-side registers to memory
// - Copy scalar-side register to primary scalar
// - Copy primary scalar into scalar-side register
// - Flagged ops differ in extended address mode
// - Address add; zero fields give copy, increment
// - Address subtract; zero fields give negate, decrement
// - Scalar add of two operands
// - Scalar subtract; zero first field negates
// - 64-bit add in eight chained 8-bit slices
// - Add result lands four clocks after start
// - First field zero supplies value zero
// - Address second field zero supplies one
`timescale 1ns/10ps
`include "intreg_consts.vh"

module intermediate_regfile_and_adder (
  input  wire        mclk_i,                  // Processor clock
  input  wire        reset_i,                 // Sync reset, high
  input  wire        op_valid_i,              // Issue presents an op
  output reg         op_ready_o,              // Op taken when both high
  input  wire [8:0]  op_code_i,               // Major opcode
  input  wire [2:0]  op_dest_i,               // i field
  input  wire [5:0]  six_bit_reg_index_i,     // Register index
  input  wire        extended_mode_i,         // 64-bit address mode
  input  wire        maintenance_mode_i,      // Maintenance mode
  input  wire [63:0] primary_address_dest_i,  // Address value
  input  wire [63:0] primary_scalar_dest_i,   // Scalar value
  input  wire [63:0] block_start_register_i,  // Block start
  input  wire [63:0] address_operand_first_i, // Address op 1
  input  wire [63:0] address_operand_second_i,// Address op 2
  input  wire [63:0] scalar_operand_first_i,  // Scalar op 1
  input  wire [63:0] scalar_operand_second_i, // Scalar op 2
  output wire        result_valid_o,          // Result word valid
  input  wire        result_ready_i,          // Result taken
  output wire        result_scalar_o,         // 1: Si, 0: Ai
  output wire [2:0]  result_dest_o,           // Destination number
  output wire [63:0] result_data_o,           // Result value
  output reg         jump_valid_o,            // Jump pulse
  output reg         jump_flush_o,            // Flush buffers too
  output reg  [63:0] jump_target_o,           // Jump address
  output reg         mem_req_o,               // Memory request
  output reg         mem_write_o,             // 1: store, 0: load
  output reg  [63:0] mem_addr_o,              // Word address
  output reg  [63:0] mem_wdata_o,             // Store data
  input  wire        mem_ack_i,               // Request accepted
  input  wire        mem_rdata_valid_i,       // Load data returns
  input  wire [63:0] mem_rdata_i,             // Load data
  input  wire        branch_wr_valid_i,       // Branch control write
  input  wire [5:0]  branch_wr_index_i,       // Address-side index
  input  wire [63:0] branch_wr_data_i         // Branch write value
);

  // ----------------------------------------------------------------
  // Transfer states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;            // Taking ops
  localparam [2:0] ST_RD   = 3'h2;            // Block load running
  localparam [2:0] ST_WR   = 3'h4;            // Block store running

  reg  [2:0]  state;                          // One-hot state
  reg  [63:0] xfer_left;                      // Requests still to send
  reg  [63:0] ret_left;                       // Load words still due
  reg  [63:0] xfer_addr;                      // Next memory address
  reg  [5:0]  xfer_idx;                       // Next store index
  reg  [5:0]  ret_idx;                        // Next load index
  reg         xfer_scalar;                    // 1: scalar-side block
  reg  [1:0]  occ;                            // Results in flight

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire       take    = op_valid_i & op_ready_o;
  wire [2:0] j_field = six_bit_reg_index_i[5:3];
  wire [2:0] k_field = six_bit_reg_index_i[2:0];
  wire is_jump  = op_code_i == `OP_JUMP;
  wire is_b2a   = op_code_i == `OP_B_TO_A;
  wire is_a2b   = op_code_i == `OP_A_TO_B;
  wire is_add_a = op_code_i == `OP_ADD_A;
  wire is_sub_a = op_code_i == `OP_SUB_A;
  wire is_add_s = op_code_i == `OP_ADD_S;
  wire is_sub_s = op_code_i == `OP_SUB_S;
  wire is_t2s   = op_code_i == `OP_T_TO_S;
  wire is_s2t   = op_code_i == `OP_S_TO_T;
  wire is_blk_rd = (op_code_i == `OP_MEM_TO_B) |
                   (op_code_i == `OP_MEM_TO_T);
  wire is_blk_wr = (op_code_i == `OP_B_TO_MEM) |
                   (op_code_i == `OP_T_TO_MEM);
  wire blk_scalar = (op_code_i == `OP_MEM_TO_T) |
                    (op_code_i == `OP_T_TO_MEM);
  wire is_addr_ar = is_add_a | is_sub_a;
  wire is_scal_ar = is_add_s | is_sub_s;
  wire is_result  = is_addr_ar | is_scal_ar | is_b2a | is_t2s;

  // Legacy mode keeps address-side values to 32 bits
  wire [63:0] mode_mask = extended_mode_i ? `FULL_MASK :
                                            `LEGACY_MASK;
  wire [63:0] blk_count = primary_address_dest_i & mode_mask;

  // ----------------------------------------------------------------
  // Storage read port: instruction fields when idle, else pointer
  // ----------------------------------------------------------------
  wire        rd_scalar = (state == ST_IDLE) ? is_t2s : xfer_scalar;
  wire [5:0]  rd_idx    = (state == ST_IDLE) ? six_bit_reg_index_i :
                                               xfer_idx;
  wire [63:0] rd_packed;                      // Slice-ordered word
  wire [63:0] rd_word = {rd_packed[63:48], rd_packed[31:16],
                         rd_packed[47:32], rd_packed[15:0]};

  // ----------------------------------------------------------------
  // Storage write port, one word per clock
  // ----------------------------------------------------------------
  reg         wr_en;                          // Write this clock
  reg         wr_scalar;                      // 1: scalar side
  reg  [5:0]  wr_idx;                         // Target index
  reg  [63:0] wr_data;                        // Target value

  // Memory returns cannot wait, so they win; branch control last
  always @* begin
    wr_en     = 1'b0;
    wr_scalar = 1'b0;
    wr_idx    = six_bit_reg_index_i;
    wr_data   = `ZERO_WORD;
    if ((state == ST_RD) && mem_rdata_valid_i) begin
      wr_en     = 1'b1;
      wr_scalar = xfer_scalar;
      wr_idx    = ret_idx;
      wr_data   = mem_rdata_i;
    end else if (take && (is_a2b || is_s2t)) begin
      wr_en     = 1'b1;
      wr_scalar = is_s2t;
      wr_data   = is_s2t ? primary_scalar_dest_i :
                  (primary_address_dest_i & mode_mask);
    end else if (branch_wr_valid_i) begin
      wr_en   = 1'b1;
      wr_idx  = branch_wr_index_i;
      wr_data = branch_wr_data_i;
    end
  end

  // Bits 15:0,47:32 go to slice 0; bits 31:16,63:48 to slice 1
  wire [63:0] wr_packed = {wr_data[63:48], wr_data[31:16],
                           wr_data[47:32], wr_data[15:0]};

  // ----------------------------------------------------------------
  // Register storage per slice
  // ----------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < `STORE_SLICES; s = s + 1) begin : store
      reg [31:0] addr_side [0:`REG_COUNT-1];
      reg [31:0] scal_side [0:`REG_COUNT-1];

      // Not reset; undefined until written
      always @(posedge mclk_i) begin
        if (wr_en && !wr_scalar)
          addr_side[wr_idx] <= wr_packed[32*s+31:32*s];
        if (wr_en && wr_scalar)
          scal_side[wr_idx] <= wr_packed[32*s+31:32*s];
      end

      assign rd_packed[32*s+31:32*s] = rd_scalar ? scal_side[rd_idx] :
                                                   addr_side[rd_idx];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Transfer control and issue credit
  // ----------------------------------------------------------------
  wire blk_start = take & (is_blk_rd | is_blk_wr) &
                   (blk_count != `ZERO_WORD);
  wire req_free  = ~mem_req_o | mem_ack_i;
  wire rd_last   = (state == ST_RD) & mem_rdata_valid_i &
                   (ret_left == `ONE_WORD);
  wire wr_done   = (state == ST_WR) & req_free &
                   (xfer_left == `ZERO_WORD);
  wire idle_next = ((state == ST_IDLE) & ~blk_start) | rd_last | wr_done;

  // At most two results in flight, so the buffer never overflows
  wire       inc      = take & is_result;
  wire       dec      = result_valid_o & result_ready_i;
  wire [1:0] next_occ = occ + {1'b0, inc} - {1'b0, dec};

  // State, memory port, jumps and ready, all registered
  always @(posedge mclk_i) begin
    if (reset_i) begin
      state         <= ST_IDLE;
      op_ready_o    <= 1'b0;
      occ           <= 2'h0;
      mem_req_o     <= 1'b0;
      mem_write_o   <= 1'b0;
      mem_addr_o    <= `ZERO_WORD;
      mem_wdata_o   <= `ZERO_WORD;
      jump_valid_o  <= 1'b0;
      jump_flush_o  <= 1'b0;
      jump_target_o <= `ZERO_WORD;
    end else begin
      occ          <= next_occ;
      op_ready_o   <= idle_next & (next_occ < `CREDIT_MAX);
      jump_valid_o <= 1'b0;
      jump_flush_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Flush form outside maintenance mode is dropped silently
          if (take && is_jump && ((op_dest_i == `JUMP_PLAIN) ||
              ((op_dest_i == `JUMP_FLUSH) && maintenance_mode_i))) begin
            jump_valid_o  <= 1'b1;
            jump_flush_o  <= op_dest_i == `JUMP_FLUSH;
            jump_target_o <= rd_word;
          end
          // Zero count finishes at once with no memory traffic
          if (blk_start) begin
            state       <= is_blk_rd ? ST_RD : ST_WR;
            xfer_left   <= blk_count;
            ret_left    <= blk_count;
            xfer_addr   <= block_start_register_i & mode_mask;
            xfer_idx    <= six_bit_reg_index_i;
            ret_idx     <= six_bit_reg_index_i;
            xfer_scalar <= blk_scalar;
          end
        end
        ST_RD: begin
          // Loads: requests run ahead, returns fill registers in order
          if (req_free) begin
            if (xfer_left != `ZERO_WORD) begin
              mem_req_o   <= 1'b1;
              mem_write_o <= 1'b0;
              mem_addr_o  <= xfer_addr;
              xfer_addr   <= xfer_addr + `ONE_WORD;
              xfer_left   <= xfer_left - `ONE_WORD;
            end else begin
              mem_req_o <= 1'b0;
            end
          end
          if (mem_rdata_valid_i) begin
            ret_idx  <= ret_idx + `IDX_ONE;
            ret_left <= ret_left - `ONE_WORD;
            if (rd_last)
              state <= ST_IDLE;
          end
        end
        ST_WR: begin
          // Stores: each word read from storage as it is requested
          if (req_free) begin
            if (xfer_left != `ZERO_WORD) begin
              mem_req_o   <= 1'b1;
              mem_write_o <= 1'b1;
              mem_addr_o  <= xfer_addr;
              mem_wdata_o <= rd_word;
              xfer_addr   <= xfer_addr + `ONE_WORD;
              xfer_idx    <= xfer_idx + `IDX_ONE;
              xfer_left   <= xfer_left - `ONE_WORD;
            end else begin
              mem_req_o   <= 1'b0;
              mem_write_o <= 1'b0;
              state       <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Add unit operand selection
  // ----------------------------------------------------------------
  reg [63:0] op_a;                            // First operand
  reg [63:0] op_b;                            // Second operand
  wire       op_sub = is_sub_a | is_sub_s;    // Subtract forms

  // Copies ride the adder with a zero addend to share its latency
  always @* begin
    op_a = `ZERO_WORD;
    op_b = `ZERO_WORD;
    if (is_b2a || is_t2s) begin
      op_a = rd_word;
    end else if (is_addr_ar) begin
      op_a = (j_field == 3'h0) ? `ZERO_WORD :
             address_operand_first_i;
      op_b = (k_field == 3'h0) ? `ONE_WORD :
             address_operand_second_i;
    end else if (is_scal_ar) begin
      op_a = (j_field == 3'h0) ? `ZERO_WORD : scalar_operand_first_i;
      op_b = (k_field == 3'h0) ? `SIGN_BIT : scalar_operand_second_i;
    end
  end

  // ----------------------------------------------------------------
  // Add pipeline: operands, sum, mask, then the result buffer
  // ----------------------------------------------------------------
  reg        s1_valid, s1_scalar, s1_cin;     // Stage 1 control
  reg [2:0]  s1_dest;                         // Stage 1 destination
  reg [63:0] s1_a, s1_b, s1_mask;             // Stage 1 operands
  reg        s2_valid, s2_scalar;             // Stage 2 control
  reg [2:0]  s2_dest;                         // Stage 2 destination
  reg [63:0] s2_sum, s2_mask;                 // Stage 2 sum
  reg        s3_valid, s3_scalar;             // Stage 3 control
  reg [2:0]  s3_dest;                         // Stage 3 destination
  reg [63:0] s3_data;                         // Stage 3 result
  wire       buf_in_ready;                    // Buffer has room
  wire       adv = ~(s3_valid & ~buf_in_ready); // Whole pipe advances
  wire [63:0] sum;                            // Sliced adder output
  wire [`ADD_SLICES:0] carry;                 // Slice carry chain

  // Eight slices; enable is the slice propagate term
  assign carry[0] = s1_cin;
  genvar g;
  generate
    for (g = 0; g < `ADD_SLICES; g = g + 1) begin : add_slice
      wire [8:0] part = {1'b0, s1_a[8*g+7:8*g]} +
                        {1'b0, s1_b[8*g+7:8*g]};
      wire       en   = &(s1_a[8*g+7:8*g] ^ s1_b[8*g+7:8*g]);
      assign sum[8*g+7:8*g] = part[7:0] + {7'h00, carry[g]};
      assign carry[g+1]     = part[8] | (en & carry[g]);
    end
  endgenerate

  // Four edges from take to result_valid_o; top carry is dropped
  always @(posedge mclk_i) begin
    if (reset_i) begin
      s1_valid <= 1'b0;
      s2_valid <= 1'b0;
      s3_valid <= 1'b0;
    end else if (adv) begin
      s1_valid  <= inc;
      s1_scalar <= is_t2s | is_scal_ar;
      s1_dest   <= op_dest_i;
      s1_a      <= op_a;
      s1_b      <= op_sub ? ~op_b : op_b;
      s1_cin    <= op_sub;
      s1_mask   <= (is_addr_ar | is_b2a) ? mode_mask : `FULL_MASK;
      s2_valid  <= s1_valid;
      s2_scalar <= s1_scalar;
      s2_dest   <= s1_dest;
      s2_sum    <= sum;
      s2_mask   <= s1_mask;
      s3_valid  <= s2_valid;
      s3_scalar <= s2_scalar;
      s3_dest   <= s2_dest;
      s3_data   <= s2_sum & s2_mask;
    end
  end

  // ----------------------------------------------------------------
  // Result buffer toward the primary register files
  // ----------------------------------------------------------------
  result_skid_buffer #(
    .WIDTH (`BUF_W)
  ) result_buf (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .in_valid_i  (s3_valid & adv),
    .in_ready_o  (buf_in_ready),
    .in_data_i   ({s3_scalar, s3_dest, s3_data}),
    .out_valid_o (result_valid_o),
    .out_ready_i (result_ready_i),
    .out_data_o  ({result_scalar_o, result_dest_o, result_data_o})
  );

endmodule

// ---- bench/mem_model.sv ----
`timescale 1ns/10ps
// ------
// Common memory: acks at once unless stalled
// ------
module mem_model (
  input  wire        mclk_i,   // Clock
  input  wire        stall_i,  // Hold off acks
  input  wire        req_i,    // Request
  input  wire        write_i,  // 1: store
  input  wire [63:0] addr_i,   // Word address
  input  wire [63:0] wdata_i,  // Store data
  output wire        ack_o,    // Accept
  output reg         rvalid_o, // Load word valid
  output reg  [63:0] rdata_o   // Load word
);
  reg [63:0] mem [0:15]; // Small image; low address bits only
  assign ack_o = req_i & ~stall_i;
  // Idle data flips so stale words never match
  initial rdata_o = 64'h0000_0000_0000_0000;
  always @(posedge mclk_i) begin
    rvalid_o <= ack_o & ~write_i;
    rdata_o  <= (ack_o & ~write_i) ? mem[addr_i[3:0]] : ~rdata_o;
    if (ack_o & write_i) mem[addr_i[3:0]] <= wdata_i;
  end
endmodule

// ---- bench/intreg_asserts.sv ----
`timescale 1ns/10ps
`include "intreg_consts.vh"
module intreg_asserts (
  input wire        mclk_i,
  input wire        reset_i,
  input wire        op_valid_i,
  input wire        op_ready_o,
  input wire [8:0]  op_code_i,
  input wire [2:0]  op_dest_i,
  input wire        maintenance_mode_i,
  input wire        result_valid_o,
  input wire        result_ready_i,
  input wire [63:0] result_data_o,
  input wire        jump_valid_o,
  input wire        jump_flush_o,
  input wire        mem_req_o,
  input wire        mem_write_o,
  input wire [63:0] mem_addr_o,
  input wire        mem_ack_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Issue take, and a take of a jump
  sequence take_s; op_valid_i && op_ready_o; endsequence
  sequence jump_s; take_s ##0 op_code_i == `OP_JUMP; endsequence
  sequence add_s;
    take_s ##0 (op_code_i == `OP_ADD_A || op_code_i == `OP_ADD_S);
  endsequence
  AST_ADD_LAT: assert property (add_s |-> ##4 result_valid_o)
    else $error("add result late");
  AST_JUMP: assert property (jump_s ##0 op_dest_i == `JUMP_PLAIN
    |=> jump_valid_o && !jump_flush_o) else $error("plain jump wrong");
  AST_FLUSH: assert property (jump_s ##0 op_dest_i == `JUMP_FLUSH
    && maintenance_mode_i |=> jump_valid_o && jump_flush_o)
    else $error("flush jump wrong");
  AST_FLUSH_OFF: assert property (jump_s ##0 op_dest_i == `JUMP_FLUSH
    && !maintenance_mode_i |=> !jump_valid_o) else $error("flush not refused");
  AST_BLOCK_BUSY: assert property (take_s ##0 op_code_i[8:2] == 7'h07
    |=> !op_ready_o) else $error("ready during block");
  AST_MEM_HOLD: assert property (mem_req_o && !mem_ack_i
    |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_write_o))
    else $error("memory request dropped");
  AST_MEM_STEP: assert property (mem_req_o && mem_ack_i ##1 mem_req_o
    |-> mem_addr_o[31:0] == $past(mem_addr_o[31:0]) + 32'h0000_0001)
    else $error("address not stepped");
  AST_RES_HOLD: assert property (result_valid_o && !result_ready_i
    |=> result_valid_o && $stable(result_data_o)) else $error("result lost");
endmodule
bind intermediate_regfile_and_adder intreg_asserts u_intreg_asserts (.*);

// ---- bench/intermediate_regfile_and_adder_tb.sv ----
`timescale 1ns/10ps
`include "intreg_consts.vh"
module intermediate_regfile_and_adder_tb;
  reg         mclk_i, reset_i, op_valid_i, extended_mode_i, stall;
  reg         maintenance_mode_i, result_ready_i, branch_wr_valid_i;
  reg  [8:0]  op_code_i;
  reg  [2:0]  op_dest_i;
  reg  [5:0]  six_bit_reg_index_i, branch_wr_index_i;
  reg  [63:0] primary_address_dest_i, primary_scalar_dest_i;
  reg  [63:0] block_start_register_i, branch_wr_data_i;
  reg  [63:0] address_operand_first_i, address_operand_second_i;
  reg  [63:0] scalar_operand_first_i, scalar_operand_second_i;
  wire        op_ready_o, result_valid_o, result_scalar_o, jump_valid_o;
  wire        jump_flush_o, mem_req_o, mem_write_o, mem_ack_i;
  wire        mem_rdata_valid_i;
  wire [2:0]  result_dest_o;
  wire [63:0] result_data_o, jump_target_o, mem_addr_o, mem_wdata_o;
  wire [63:0] mem_rdata_i;
  integer     fails, cmp_count, n;
  intermediate_regfile_and_adder u_intermediate_regfile_and_adder (.*);
  mem_model u_mem_model (.mclk_i(mclk_i), .stall_i(stall), .req_i(mem_req_o),
    .write_i(mem_write_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .ack_o(mem_ack_i), .rvalid_o(mem_rdata_valid_i), .rdata_o(mem_rdata_i));
  always #12.5 mclk_i = ~mclk_i;
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  // Idle a cycle, offer the op, drop it after the take edge
  task issue(input [8:0] op, input [2:0] d, input [5:0] idx);
    begin
      @(negedge mclk_i);
      {op_code_i, op_dest_i, six_bit_reg_index_i} = {op, d, idx};
      op_valid_i = 1'b1;
      for (n = 0; op_ready_o !== 1'b1 && n < 400; n = n + 1)
        @(negedge mclk_i);
      if (n == 400) fails = fails + 1;
      @(negedge mclk_i);
      op_valid_i = 1'b0;
    end
  endtask
  task res(input [63:0] exp);
    begin
      for (n = 0; result_valid_o !== 1'b1 && n < 40; n = n + 1)
        @(negedge mclk_i);
      chk(result_valid_o, 1'b1);
      chk(result_data_o, exp);
      @(negedge mclk_i);
    end
  endtask
  task opr(input [8:0] op, input [5:0] idx, input [63:0] exp);
    begin
      issue(op, 3'h1, idx);
      res(exp);
    end
  endtask
  task jmp(input [2:0] d, input v);
    begin
      issue(`OP_JUMP, d, 6'h3f);
      chk(jump_valid_o, v);
      chk(jump_flush_o, v & d[0]);
      @(negedge mclk_i);
    end
  endtask
  task summarize;
    begin
      if (fails == 0 && cmp_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    #600000;
    fails = fails + 1;
    summarize;
  end
  initial begin
    {mclk_i, op_valid_i, maintenance_mode_i, branch_wr_valid_i, stall} = '0;
    {op_code_i, op_dest_i, six_bit_reg_index_i, branch_wr_index_i} = '0;
    {primary_address_dest_i, primary_scalar_dest_i, branch_wr_data_i} = '0;
    {address_operand_first_i, address_operand_second_i} = '0;
    {scalar_operand_first_i, block_start_register_i} = '0;
    scalar_operand_second_i = 64'h0000_0000_0000_0002;
    {reset_i, result_ready_i, extended_mode_i} = 3'h7;
    {fails, cmp_count} = '0;
    repeat (6) @(negedge mclk_i);
    reset_i = 1'b0;
    // Adder: slice carries, zero fields, wrap, legacy mask
    address_operand_first_i = 64'h00ff_ffff_ffff_ff80;
    address_operand_second_i = 64'h0000_0000_0000_0090;
    scalar_operand_first_i = 64'hffff_ffff_ffff_ffff;
    opr(`OP_ADD_A, 6'h0a, 64'h0100_0000_0000_0010);
    opr(`OP_ADD_A, 6'h02, 64'h0000_0000_0000_0090);
    opr(`OP_ADD_A, 6'h08, 64'h00ff_ffff_ffff_ff81);
    opr(`OP_SUB_A, 6'h02, 64'hffff_ffff_ffff_ff70);
    opr(`OP_SUB_A, 6'h08, 64'h00ff_ffff_ffff_ff7f);
    opr(`OP_ADD_S, 6'h0a, 64'h0000_0000_0000_0001);
    opr(`OP_SUB_S, 6'h02, 64'hffff_ffff_ffff_fffe);
    extended_mode_i = 1'b0;
    opr(`OP_ADD_A, 6'h0a, 64'h0000_0000_0000_0010);
    extended_mode_i = 1'b1;
    // Copies; same index in both files stays apart
    primary_address_dest_i = 64'h1234_5678_9abc_def0;
    primary_scalar_dest_i = 64'h0fed_cba9_8765_4321;
    issue(`OP_A_TO_B, 3'h0, 6'h3f);
    issue(`OP_S_TO_T, 3'h0, 6'h3f);
    opr(`OP_B_TO_A, 6'h3f, 64'h1234_5678_9abc_def0);
    opr(`OP_T_TO_S, 6'h3f, 64'h0fed_cba9_8765_4321);
    // Blocks of two words, index wrap, stalled memory
    primary_address_dest_i = 64'haaaa_5555_0f0f_f0f0;
    issue(`OP_A_TO_B, 3'h0, 6'h00);
    {primary_address_dest_i, block_start_register_i, stall} = {64'h2, 64'h5, 1'b1};
    issue(`OP_B_TO_MEM, 3'h0, 6'h3f);
    repeat (3) @(negedge mclk_i);
    stall = 1'b0;
    issue(`OP_MEM_TO_T, 3'h0, 6'h10);
    chk(u_mem_model.mem[5], 64'h1234_5678_9abc_def0);
    chk(u_mem_model.mem[6], 64'haaaa_5555_0f0f_f0f0);
    opr(`OP_T_TO_S, 6'h10, 64'h1234_5678_9abc_def0);
    opr(`OP_T_TO_S, 6'h11, 64'haaaa_5555_0f0f_f0f0);
    block_start_register_i = 64'h0000_0000_0000_0008;
    issue(`OP_T_TO_MEM, 3'h0, 6'h10);
    issue(`OP_MEM_TO_B, 3'h0, 6'h20);
    opr(`OP_B_TO_A, 6'h20, 64'h1234_5678_9abc_def0);
    opr(`OP_B_TO_A, 6'h21, 64'haaaa_5555_0f0f_f0f0);
    // Jumps; flush form only in maintenance mode
    jmp(`JUMP_PLAIN, 1'b1);
    chk(jump_target_o, 64'h1234_5678_9abc_def0);
    jmp(`JUMP_FLUSH, 1'b0);
    maintenance_mode_i = 1'b1;
    jmp(`JUMP_FLUSH, 1'b1);
    // Stalled consumer: two results wait, issue holds off
    result_ready_i = 1'b0;
    issue(`OP_ADD_S, 3'h1, 6'h0a);
    issue(`OP_ADD_S, 3'h1, 6'h02);
    repeat (6) @(negedge mclk_i);
    chk(op_ready_o, 1'b0);
    result_ready_i = 1'b1;
    res(64'h0000_0000_0000_0001);
    res(64'h0000_0000_0000_0002);
    @(negedge mclk_i) branch_wr_valid_i = 1'b1;
    branch_wr_data_i = 64'h0000_0000_0000_0005;
    @(negedge mclk_i) branch_wr_valid_i = 1'b0;
    opr(`OP_B_TO_A, 6'h00, 64'h0000_0000_0000_0005);
    summarize;
  end
endmodule
